// ==== core/dio_decode_irq.sv ====
// address decoder and interrupt request glue for the six-channel i/o card
`timescale 1ns/1ps
`default_nettype none
module dio_decode_irq (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // isa address and strobes
   input  wire logic [9:0]             isa_addr,
   input  wire logic                   isa_aen,
   input  wire logic                   isa_ior_n,
   input  wire logic                   isa_iow_n,
   // configuration switches and jumpers
   input  wire logic [4:0]             base_address_switch,
   input  wire logic                   capacity_mode_switch,
   input  wire logic [8:0]             irq_level_jumper,
   input  wire logic [17:0]            channel_irq_mode_jumper,
   // field port c lines, per channel
   input  wire logic [5:0]             port_c_line_zero,
   input  wire logic [5:0]             port_c_line_three,
   input  wire logic [5:0]             port_c_gate_line,
   // decode results
   output logic                        card_select,
   output logic [5:0]                  chan_select,
   output logic [1:0]                  port_select,
   output logic                        read_strobe,
   output logic                        write_strobe,
   // interrupt request pins, one per routable level
   output logic [8:0]                  irq_out,
   output logic [8:0]                  irq_oe,
   // per-channel request pulses, for visibility
   output logic [5:0]                  chan_request
);
   logic [5:0] sync_zero;
   logic [5:0] sync_three;
   logic [5:0] sync_gate;
   logic [5:0] rise_zero;
   logic [5:0] fall_three;
   logic [5:0] next_request;
   logic       mode_144;
   logic [8:0] level_sel;
   logic       hit;
   logic [4:0] offset;
   logic [2:0] chan_idx;
   logic       chan_ok;
   logic       any_req;

   // capacity switch and level jumper are static; caught once after reset release
   logic       cfg_loaded;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_loaded <= 1'h0;
         mode_144   <= dio_pkg::MODE_144;
         level_sel  <= dio_pkg::IRQ_LEVEL_RESET;
      end else if (!cfg_loaded) begin
         cfg_loaded <= 1'h1;
         mode_144   <= capacity_mode_switch;
         level_sel  <= irq_level_jumper;
      end
   end

   // address window match
   always_comb begin
      hit = 1'h0;
      if (!isa_addr[dio_pkg::A9_POS] || isa_aen) begin
         hit = 1'h0;
      end else if (mode_144 == dio_pkg::MODE_144) begin
         // low switch bit is a don't care here
         hit = isa_addr[dio_pkg::SW_HI:dio_pkg::SW_LO+1]
            == base_address_switch[4:1];
      end else begin
         hit = isa_addr[dio_pkg::SW_HI:dio_pkg::SW_LO]
            == base_address_switch;
      end
   end

   always_comb begin
      if (mode_144 == dio_pkg::MODE_144) begin
         offset = isa_addr[dio_pkg::OFF_HI:0];
      end else begin
         offset = {1'h0, isa_addr[3:0]};
      end
      chan_idx = offset[4:2];
      if (offset >= dio_pkg::CH_OFF_END) begin
         chan_ok = 1'h0;
      end else if (mode_144 != dio_pkg::MODE_144
                   && chan_idx >= 3'(dio_pkg::NUM_CH_SMALL)) begin
         chan_ok = 1'h0;
      end else begin
         chan_ok = 1'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         card_select  <= 1'h0;
         chan_select  <= 6'h00;
         port_select  <= 2'h0;
         read_strobe  <= 1'h0;
         write_strobe <= 1'h0;
      end else begin
         card_select  <= hit;
         chan_select  <= (hit && chan_ok) ? 6'(6'h01 << chan_idx) : 6'h00;
         port_select  <= offset[1:0];
         read_strobe  <= hit && chan_ok && !isa_ior_n;
         write_strobe <= hit && chan_ok && !isa_iow_n;
      end
   end

   // input synchronisers
   dio_sync2 #(.W(6)) u_sync_zero (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (port_c_line_zero),
      .dout  (sync_zero)
   );
   dio_sync2 #(.W(6)) u_sync_three (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (port_c_line_three),
      .dout  (sync_three)
   );
   dio_sync2 #(.W(6)) u_sync_gate (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (port_c_gate_line),
      .dout  (sync_gate)
   );

   // nothing is latched: sources live only as edges
   genvar g;
   generate
      for (g = 0; g < dio_pkg::NUM_CH; g++) begin : gen_ch
         logic [2:0] jmode;
         dio_edge u_edge (
            .clk        (clk),
            .rst_n      (rst_n),
            .line_zero  (sync_zero[g]),
            .line_three (sync_three[g]),
            .rise_zero  (rise_zero[g]),
            .fall_three (fall_three[g])
         );
         assign jmode = channel_irq_mode_jumper[3*g +: 3];
         always_comb begin
            next_request[g] = 1'h0;
            case (jmode)
               dio_pkg::dio_irq_gated:
                  next_request[g] = !sync_gate[g]
                     && (rise_zero[g] || fall_three[g]);
               dio_pkg::dio_irq_always:
                  next_request[g] = rise_zero[g] || fall_three[g];
               default:
                  next_request[g] = 1'h0;
            endcase
            if (mode_144 != dio_pkg::MODE_144
                && g >= dio_pkg::NUM_CH_SMALL) begin
               next_request[g] = 1'h0;
            end
         end
      end
   endgenerate

   assign any_req = |next_request;

   // drive the pulse only on the selected level, float the rest
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_request <= 6'h00;
         irq_out      <= 9'h000;
         irq_oe       <= 9'h000;
      end else begin
         chan_request <= next_request;
         irq_out      <= any_req ? level_sel : 9'h000;
         irq_oe       <= any_req ? level_sel : 9'h000;
      end
   end
endmodule
`default_nettype wire

// ==== core/dio_pkg.sv ====
// constants for the digital i/o card decoder and interrupt glue
package dio_pkg;
   localparam int       NUM_CH        = 6;
   localparam int       NUM_CH_SMALL  = 4;
   localparam int       ADDR_W        = 10;
   localparam int       NUM_IRQ       = 9;
   // capacity mode switch: 1 = 144-line (factory), 0 = 96-line
   localparam logic     MODE_144      = 1'h1;
   localparam logic     MODE_96       = 1'h0;
   // window sizes in addresses
   localparam int       WIN_144       = 32;
   localparam int       WIN_96        = 16;
   // address field positions
   localparam int       A9_POS        = 9;
   localparam int       SW_HI         = 8;
   localparam int       SW_LO         = 4;
   localparam int       OFF_HI        = 4;
   localparam logic [4:0] CH_OFF_END  = 5'h18;
   // interrupt level jumper, one-hot over lines 3,5,6,7,9,10,11,12,15
   localparam logic [8:0] IRQ_LEVEL_RESET = 9'h100;
   // per-channel mode jumper codes, one-hot
   typedef enum logic [2:0] {
      dio_irq_off    = 3'h1,
      dio_irq_gated  = 3'h2,
      dio_irq_always = 3'h4
   } dio_irq_mode_t;
   // port c bit positions
   localparam int       PC_ZERO       = 0;
   localparam int       PC_THREE      = 3;
   localparam int       PC_GATE       = 4;
endpackage

// ==== core/dio_sync2.sv ====
// two flop synchroniser for a bus of levels
`timescale 1ns/1ps
`default_nettype none
module dio_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== core/dio_edge.sv ====
// edge detector for one channel's two request lines
`timescale 1ns/1ps
`default_nettype none
module dio_edge (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // synchronised levels
   input  wire logic line_zero,
   input  wire logic line_three,
   // detected edges, one-cycle pulses
   output logic      rise_zero,
   output logic      fall_three
);
   logic prev_zero;
   logic prev_three;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_zero  <= 1'h0;
         prev_three <= 1'h0;
      end else begin
         prev_zero  <= line_zero;
         prev_three <= line_three;
      end
   end

   assign rise_zero  = line_zero & ~prev_zero;
   assign fall_three = ~line_three & prev_three;
endmodule
`default_nettype wire

// ==== tb/dio_decode_irq_chk.sv ====
// assertions for the decoder and interrupt glue
`timescale 1ns/1ps
`default_nettype none
module dio_decode_irq_chk (
   input wire logic        clk, rst_n, isa_aen, isa_ior_n,
   input wire logic        capacity_mode_switch, card_select, read_strobe,
   input wire logic [9:0]  isa_addr,
   input wire logic [4:0]  base_address_switch,
   input wire logic [8:0]  irq_level_jumper, irq_out, irq_oe,
   input wire logic [17:0] channel_irq_mode_jumper,
   input wire logic [5:0]  port_c_line_zero, port_c_line_three,
   input wire logic [5:0]  port_c_gate_line, chan_select, chan_request
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_hit;
      $past(isa_addr[9]) && !$past(isa_aen)
      && $past(isa_addr[8:5]) == base_address_switch[4:1];
   endsequence
   property p_hit;
      card_select |-> s_hit;
   endproperty
   a_hit: assert property (p_hit) else $error("bad claim");
   property p_rd;
      read_strobe |-> card_select && !$past(isa_ior_n) && |chan_select;
   endproperty
   a_rd: assert property (p_rd) else $error("bad read strobe");
   property p_oe;
      (irq_out & ~irq_oe) == 9'h000;
   endproperty
   a_oe: assert property (p_oe) else $error("undriven high");
   property p_irq;
      irq_oe == ({9{|chan_request}} & irq_level_jumper);
   endproperty
   a_irq: assert property (p_irq) else $error("wrong irq line");
   for (genvar i = 0; i < 6; i++) begin : g_ch
      wire logic [2:0] m = channel_irq_mode_jumper[3*i+:3];
      wire logic       on = (i < 4) || capacity_mode_switch;
      sequence s_low;
         !port_c_gate_line[i] [*4] ##0 $fell(port_c_line_three[i]);
      endsequence
      property p_off;
         m != 3'h2 && m != 3'h4 |-> !chan_request[i];
      endproperty
      a_off: assert property (p_off) else $error("off requested");
      property p_gate;
         (m == 3'h2 && port_c_gate_line[i]) [*4] |=> !chan_request[i];
      endproperty
      a_gate: assert property (p_gate) else $error("gate leak");
      property p_rise;
         m == 3'h4 && on && $rose(port_c_line_zero[i])
         |-> ##[1:4] chan_request[i];
      endproperty
      a_rise: assert property (p_rise) else $error("rise lost");
      property p_fall;
         m == 3'h2 && on ##0 s_low |-> ##[1:4] chan_request[i];
      endproperty
      a_fall: assert property (p_fall) else $error("fall lost");
   end
endmodule
bind dio_decode_irq dio_decode_irq_chk i_chk (.clk(clk), .rst_n(rst_n),
   .isa_aen(isa_aen), .isa_ior_n(isa_ior_n), .isa_addr(isa_addr),
   .capacity_mode_switch(capacity_mode_switch), .card_select(card_select),
   .read_strobe(read_strobe), .base_address_switch(base_address_switch),
   .irq_level_jumper(irq_level_jumper), .irq_out(irq_out), .irq_oe(irq_oe),
   .channel_irq_mode_jumper(channel_irq_mode_jumper),
   .port_c_line_zero(port_c_line_zero), .chan_select(chan_select),
   .port_c_line_three(port_c_line_three), .chan_request(chan_request),
   .port_c_gate_line(port_c_gate_line));
`default_nettype wire

// ==== tb/dio_host_model.sv ====
// host interrupt controller: counts pulses on one request line
`timescale 1ns/1ps
`default_nettype none
module dio_host_model #(
   parameter int LINE = 0
) (
   input  wire logic       clk,
   input  wire logic [8:0] irq_out, irq_oe,
   output var  int         irq_count
);
   logic lvl, lvl_q;
   // released line falls to the pull-down level
   assign lvl = irq_oe[LINE] ? irq_out[LINE] : 1'h0;
   initial irq_count = 0;
   always @(posedge clk) begin
      lvl_q <= lvl;
      if (lvl && !lvl_q) irq_count <= irq_count + 1;
   end
endmodule
`default_nettype wire

// ==== tb/dio_decode_irq_test.sv ====
// self-checking bench for the decoder and interrupt glue
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   miscompares++; $display("Error %0t: %h vs %h", $time, a, b); end end
module dio_decode_irq_test;
   logic       clk = 0, rst_n = 0, aen = 0, ior_n = 1, cap = 1;
   logic [9:0] addr = 10'h000;
   logic [5:0] z = 6'h00, t = 6'h3F, g = 6'h00, cse, req;
   logic       cs, rs, ws, iow_n = 1, wr = 0;
   logic [1:0] ps;
   logic [8:0] io, oe;
   int         miscompares = 0, total_checks = 0, n;
   always #50 clk = ~clk;
   dio_decode_irq i_dio_decode_irq (.clk(clk), .rst_n(rst_n),
      .isa_addr(addr), .isa_aen(aen), .isa_ior_n(ior_n),
      .isa_iow_n(iow_n), .base_address_switch(5'h0C),
      .capacity_mode_switch(cap), .irq_level_jumper(9'h001),
      .channel_irq_mode_jumper({3'h4, 3'h4, 3'h4, 3'h1, 3'h2, 3'h4}),
      .port_c_line_zero(z), .port_c_line_three(t), .port_c_gate_line(g),
      .card_select(cs), .chan_select(cse), .port_select(ps),
      .read_strobe(rs), .write_strobe(ws), .irq_out(io), .irq_oe(oe),
      .chan_request(req));
   dio_host_model #(.LINE(0)) i_dio_host_model (.clk(clk), .irq_out(io),
      .irq_oe(oe), .irq_count(n));
   task automatic dec(input logic [9:0] a, input logic c,
                      input logic [5:0] ch, input logic [1:0] p);
      @(negedge clk);
      addr = a;
      if (wr) iow_n = 0;
      else ior_n = 0;
      @(negedge clk);
      `CHK(cs, c)
      `CHK(cse, ch)
      `CHK(rs, |ch & !wr)
      `CHK(ws, |ch & wr)
      if (|ch) `CHK(ps, p)
      ior_n = 1;
      iow_n = 1;
   endtask
   // gate settles first so the synchroniser sees it before the edge
   task automatic edg(input int ch, input logic zv, tv, gv, input int e);
      int c0;
      c0 = n;
      @(negedge clk);
      g[ch] = gv;
      repeat (4) @(negedge clk);
      z[ch] = zv;
      t[ch] = tv;
      repeat (6) @(negedge clk);
      `CHK(n - c0, e)
   endtask
   task automatic t_reset;
      repeat (20) @(negedge clk);
      `CHK(oe, 9'h000)
      `CHK(cs, 1'h0)
      rst_n = 1;
      repeat (2) @(negedge clk);
      $display("reset test done");
   endtask
   task automatic t_decode;
      dec(10'h2C0, 1, 6'h01, 0);
      dec(10'h2D7, 1, 6'h20, 3);
      dec(10'h2DA, 1, 6'h00, 0);
      wr = 1;
      dec(10'h2C9, 1, 6'h04, 1);
      dec(10'h2DC, 1, 6'h00, 0);
      wr = 0;
      dec(10'h2E0, 0, 6'h00, 0);
      dec(10'h3C0, 0, 6'h00, 0);
      dec(10'h0C0, 0, 6'h00, 0);
      $display("decode test done");
   endtask
   task automatic t_irq;
      edg(0, 1, 1, 0, 1);
      edg(0, 0, 1, 0, 0);
      edg(1, 0, 0, 0, 1);
      edg(1, 0, 1, 1, 0);
      edg(1, 0, 0, 1, 0);
      edg(2, 1, 1, 0, 0);
      edg(5, 1, 1, 1, 1);
      $display("irq test done");
   endtask
   task automatic t_small;
      @(negedge clk);
      cap = 0;
      rst_n = 0;
      z = 6'h00;
      t = 6'h3F;
      g = 6'h00;
      repeat (2) @(negedge clk);
      rst_n = 1;
      repeat (2) @(negedge clk);
      dec(10'h2CC, 1, 6'h08, 0);
      dec(10'h2D0, 0, 6'h00, 0);
      edg(5, 1, 1, 0, 0);
      edg(3, 1, 1, 0, 1);
      $display("small mode test done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      t_reset();
      t_decode();
      t_irq();
      t_small();
      report_and_stop();
   end
   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
